// ### common/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register byte offsets
`define TCC_CMD_OFF        8'h00
`define TCC_MODE_OFF       8'h04
`define TCC_COUNT_OFF      8'h10
`define TCC_CAPA_OFF       8'h14
`define TCC_CAPB_OFF       8'h18
`define TCC_CMPC_OFF       8'h1c
`define TCC_STATE_OFF      8'h20
`define TCC_SYNC_OFF       8'hc0

// command word bits
`define TCC_CMD_ON_BIT     0
`define TCC_CMD_OFF_BIT    1
`define TCC_CMD_TRIG_BIT   2
`define TCC_SYNC_BIT       0

// mode word fields (capture layout)
`define TCC_SRC_LSB        0
`define TCC_INV_BIT        3
`define TCC_GATE_LSB       4
`define TCC_HALT_BIT       6
`define TCC_OFFLD_BIT      7
`define TCC_TEDGE_LSB      8
`define TCC_TLINE_BIT      10
`define TCC_MATCH_BIT      14
`define TCC_WAVE_BIT       15
`define TCC_LDA_LSB        16
`define TCC_LDB_LSB        18
`define TCC_MODE_MASK      32'h000f_c7ff
`define TCC_MODE_RESET     32'h0000_0000

// status word bits
`define TCC_ST_ON_BIT      0
`define TCC_ST_HALT_BIT    1
`define TCC_ST_IOA_BIT     2
`define TCC_ST_IOB_BIT     3

// master clock divider width (largest ratio 1024)
`define TCC_DIV_W          10

`endif

// ### common/tcc_div_if.sv
`timescale 1ns/1ps
// divided master clock levels: /2, /8, /32, /128, /1024
interface tcc_div_if;
  logic [4:0] div_lvl;
  modport src (output div_lvl);
  modport snk (input  div_lvl);
endinterface : tcc_div_if

// ### common/tcc_pkg.sv
package tcc_pkg;

  // counter clock state, one-hot
  typedef enum logic [2:0] {
    CS_OFF  = 3'b001,
    CS_RUN  = 3'b010,
    CS_HALT = 3'b100
  } clk_state_t;

  // edge selection code shared by trigger and load fields
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_sel_t;

  // true when the chosen edge kind has happened
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction : edge_hit

endpackage : tcc_pkg

// ### logic/master_divider.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module master_divider (
  input  wire logic pclk,
  input  wire logic presetn,
  tcc_div_if.src    div
);
  logic [`TCC_DIV_W-1:0] div_r;   // free-running prescaler
  logic [`TCC_DIV_W-1:0] div_nxt;

  // free-running count; never reset by triggers so ratios stay exact
  always_comb begin
    div_nxt = div_r + `TCC_DIV_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // bit k toggles every 2^k cycles: period 2^(k+1)
  assign div.div_lvl = {div_r[9], div_r[6], div_r[4], div_r[2], div_r[0]};
endmodule : master_divider

// ### logic/pin_sync_edge.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module pin_sync_edge (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      lvl,
  output logic      rise,
  output logic      fall
);
  logic s1_r, s2_r, s3_r;   // two-stage sync plus history
  logic s1_nxt, s2_nxt, s3_nxt;

  // shift the pin through; s1 feeds s2 only
  always_comb begin
    s1_nxt = pin_in;
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end

  assign lvl  = s2_r;
  assign rise = s2_r & ~s3_r;
  assign fall = ~s2_r & s3_r;
endmodule : pin_sync_edge

// ### logic/timer_channel_capture_control.sv
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module timer_channel_capture_control
  import tcc_pkg::*;
#(
  parameter int CNT_W  = 16,   // counter width
  parameter int ADDR_W = 8     // apb address width
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              block_sync,
  input  wire logic              io_line_a_i,
  output logic                   io_line_a_o,
  output logic                   io_line_a_oe_n,
  input  wire logic              io_line_b_i,
  output logic                   io_line_b_o,
  output logic                   io_line_b_oe_n,
  input  wire logic              ext_clock_0,
  input  wire logic              ext_clock_1,
  input  wire logic              ext_clock_2,
  output logic                   count_running
);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  ////////////////////////////////////////////////////////////////////////////
  if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt
    $error("counter width must be 2..32");
  end
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("address width must be 8..32");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and divider
  ////////////////////////////////////////////////////////////////////////////
  logic [4:0] pin_raw;    // io a, io b, ext 0..2
  logic [4:0] pin_lvl;    // synchronised levels
  logic [4:0] pin_rise;   // one-cycle rising pulses
  logic [4:0] pin_fall;   // one-cycle falling pulses

  assign pin_raw = {ext_clock_2, ext_clock_1, ext_clock_0, io_line_b_i, io_line_a_i};

  // all pins are asynchronous; each passes two flops first
  for (genvar gi = 0; gi < 5; gi++) begin : g_pin
    pin_sync_edge u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (pin_raw[gi]),
      .lvl     (pin_lvl[gi]),
      .rise    (pin_rise[gi]),
      .fall    (pin_fall[gi])
    );
  end

  tcc_div_if div_bus ();   // divided master clock levels

  master_divider u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div     (div_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]      mode_r, mode_nxt;        // capture_mode_config
  logic [CNT_W-1:0] cmp_c_r, cmp_c_nxt;      // compare_reg_c
  logic [CNT_W-1:0] cnt_r, cnt_nxt;          // counter value
  logic [CNT_W-1:0] cap_a_r, cap_a_nxt;      // capture_reg_a
  logic [CNT_W-1:0] cap_b_r, cap_b_nxt;      // capture_reg_b
  clk_state_t       cs_r, cs_nxt;            // counter clock state
  logic             gclk_r, gclk_nxt;        // gated count clock level
  logic             hit_c_r, hit_c_nxt;      // match with register c
  logic [31:0]      prdata_r, prdata_nxt;
  logic             pready_r, pready_nxt;
  logic             perr_r, perr_nxt;
  logic             run_r, run_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  ////////////////////////////////////////////////////////////////////////////
  logic       take;       // access phase completing this edge
  logic       wr;         // completing write
  logic [7:0] a8;         // low address byte
  logic       hi_zero;    // upper address bits clear
  logic       mapped;     // address hits a register

  assign take    = psel & penable & pready_r;
  assign wr      = take & pwrite;
  assign a8      = paddr[7:0];
  assign hi_zero = (paddr >> 8) == '0;
  assign mapped  = hi_zero & ((a8 == `TCC_CMD_OFF)   | (a8 == `TCC_MODE_OFF)  |
                              (a8 == `TCC_COUNT_OFF) | (a8 == `TCC_CAPA_OFF)  |
                              (a8 == `TCC_CAPB_OFF)  | (a8 == `TCC_CMPC_OFF)  |
                              (a8 == `TCC_STATE_OFF) | (a8 == `TCC_SYNC_OFF));

  // commands decoded from the write-only words
  logic cmd_wr, sync_wr;
  logic on_cmd, off_cmd, soft_trig;
  assign cmd_wr    = wr & hi_zero & (a8 == `TCC_CMD_OFF);
  assign sync_wr   = wr & hi_zero & (a8 == `TCC_SYNC_OFF);
  assign on_cmd    = cmd_wr & pwdata[`TCC_CMD_ON_BIT];
  assign off_cmd   = cmd_wr & pwdata[`TCC_CMD_OFF_BIT];
  assign soft_trig = (cmd_wr & pwdata[`TCC_CMD_TRIG_BIT])
                   | (sync_wr & pwdata[`TCC_SYNC_BIT]) | block_sync;

  ////////////////////////////////////////////////////////////////////////////
  // mode field views
  ////////////////////////////////////////////////////////////////////////////
  logic      capture;      // channel in capture mode
  logic [2:0] src_sel;
  logic      inv;
  logic [1:0] gate_sel;
  logic [1:0] trig_edge;
  logic [1:0] lda_edge, ldb_edge;

  assign capture   = ~mode_r[`TCC_WAVE_BIT];
  assign src_sel   = mode_r[`TCC_SRC_LSB +: 3];
  assign inv       = mode_r[`TCC_INV_BIT];
  assign gate_sel  = mode_r[`TCC_GATE_LSB +: 2];
  assign trig_edge = mode_r[`TCC_TEDGE_LSB +: 2];
  assign lda_edge  = mode_r[`TCC_LDA_LSB +: 2];
  assign ldb_edge  = mode_r[`TCC_LDB_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // events
  ////////////////////////////////////////////////////////////////////////////
  logic t_rise, t_fall;   // chosen trigger line edges
  logic ext_trig;         // external trigger event
  logic load_a, load_b;   // capture load strobes
  logic trigger;          // any restart source
  logic cnt_edge;         // active edge of count clock
  logic running;          // clock enabled and not halted

  // line select zero picks io line b
  assign t_rise   = mode_r[`TCC_TLINE_BIT] ? pin_rise[0] : pin_rise[1];
  assign t_fall   = mode_r[`TCC_TLINE_BIT] ? pin_fall[0] : pin_fall[1];
  assign ext_trig = capture & edge_hit(trig_edge, t_rise, t_fall);
  assign load_a   = capture & edge_hit(lda_edge, pin_rise[0], pin_fall[0]);
  assign load_b   = capture & edge_hit(ldb_edge, pin_rise[0], pin_fall[0]);
  // match restart only honoured when its enable bit is set
  assign trigger  = soft_trig | ext_trig
                  | (capture & mode_r[`TCC_MATCH_BIT] & hit_c_r);
  assign running  = (cs_r == CS_RUN);
  // inverted selection counts on the falling edge of the gated clock
  assign cnt_edge = inv ? (gclk_r & ~gclk_nxt) : (~gclk_r & gclk_nxt);

  ////////////////////////////////////////////////////////////////////////////
  // count clock selection and gating
  ////////////////////////////////////////////////////////////////////////////
  logic sel_lvl;    // selected source level
  logic gate_lvl;   // gating level

  always_comb begin
    // codes 0..4 are master divisions, 5..7 the external clocks
    unique case (src_sel)
      3'h0, 3'h1, 3'h2, 3'h3, 3'h4: sel_lvl = div_bus.div_lvl[src_sel];
      default:                      sel_lvl = pin_lvl[src_sel - 3'h3];
    endcase
    // gate code 0 passes the clock unchanged
    unique case (gate_sel)
      2'h0:    gate_lvl = 1'b1;
      default: gate_lvl = pin_lvl[{1'b0, gate_sel} + 3'h1];
    endcase
    gclk_nxt = sel_lvl & gate_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter clock state machine
  ////////////////////////////////////////////////////////////////////////////
  // disable has top priority; a trigger only restarts a halted clock,
  // so a disabled clock needs an enable command before it counts again
  always_comb begin
    cs_nxt = cs_r;
    unique case (cs_r)
      CS_OFF: begin
        if (on_cmd && !off_cmd) begin
          cs_nxt = CS_RUN;
        end
      end
      CS_RUN: begin
        if (off_cmd) begin
          cs_nxt = CS_OFF;
        end else if (load_b && mode_r[`TCC_OFFLD_BIT]) begin
          cs_nxt = CS_OFF;
        end else if (load_b && mode_r[`TCC_HALT_BIT] && !trigger) begin
          cs_nxt = CS_HALT;
        end
      end
      CS_HALT: begin
        if (off_cmd) begin
          cs_nxt = CS_OFF;
        end else if (load_b && mode_r[`TCC_OFFLD_BIT]) begin
          cs_nxt = CS_OFF;
        end else if (trigger) begin
          cs_nxt = CS_RUN;
        end
      end
      default: cs_nxt = CS_OFF;   // illegal code recovers to off
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, captures and match
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    cnt_nxt   = cnt_r;
    cap_a_nxt = cap_a_r;
    cap_b_nxt = cap_b_r;
    hit_c_nxt = 1'b0;
    // a restart beats a count edge in the same cycle
    if (trigger) begin
      cnt_nxt = '0;
    end else if (running && cnt_edge) begin
      cnt_nxt   = cnt_r + CNT_W'(1);
      hit_c_nxt = (cnt_nxt == cmp_c_r);
    end
    // captures take the value present when the edge is seen
    if (load_a) begin
      cap_a_nxt = cnt_r;
    end
    if (load_b) begin
      cap_b_nxt = cnt_r;
    end
    run_nxt = (cs_nxt == CS_RUN);
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mode_nxt  = mode_r;
    cmp_c_nxt = cmp_c_r;
    // waveform bit is stored; trigger, load and match fields act only while it is zero, clock fields always act
    if (wr && hi_zero && a8 == `TCC_MODE_OFF) begin
      mode_nxt = pwdata & `TCC_MODE_MASK;
    end
    if (wr && hi_zero && a8 == `TCC_CMPC_OFF) begin
      cmp_c_nxt = pwdata[CNT_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer
  ////////////////////////////////////////////////////////////////////////////
  // data is registered in the setup cycle, so the access phase
  // completes in its first cycle with no wait state
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    pready_nxt = psel & ~penable;
    perr_nxt   = psel & ~penable & ~mapped;
    if (psel && !penable && !pwrite && hi_zero) begin
      unique case (a8)
        `TCC_MODE_OFF:  prdata_nxt = mode_r;
        `TCC_COUNT_OFF: prdata_nxt = 32'(cnt_r);
        `TCC_CAPA_OFF:  prdata_nxt = 32'(cap_a_r);
        `TCC_CAPB_OFF:  prdata_nxt = 32'(cap_b_r);
        `TCC_CMPC_OFF:  prdata_nxt = 32'(cmp_c_r);
        `TCC_STATE_OFF: begin
          prdata_nxt[`TCC_ST_ON_BIT]   = (cs_r != CS_OFF);
          prdata_nxt[`TCC_ST_HALT_BIT] = (cs_r == CS_HALT);
          prdata_nxt[`TCC_ST_IOA_BIT]  = pin_lvl[0];
          prdata_nxt[`TCC_ST_IOB_BIT]  = pin_lvl[1];
        end
        default:        prdata_nxt = 32'h0000_0000;   // write-only or unmapped
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r   <= `TCC_MODE_RESET;
      cmp_c_r  <= '0;
      cnt_r    <= '0;
      cap_a_r  <= '0;
      cap_b_r  <= '0;
      cs_r     <= CS_OFF;
      gclk_r   <= 1'b0;
      hit_c_r  <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      perr_r   <= 1'b0;
      run_r    <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      cmp_c_r  <= cmp_c_nxt;
      cnt_r    <= cnt_nxt;
      cap_a_r  <= cap_a_nxt;
      cap_b_r  <= cap_b_nxt;
      cs_r     <= cs_nxt;
      gclk_r   <= gclk_nxt;
      hit_c_r  <= hit_c_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      perr_r   <= perr_nxt;
      run_r    <= run_nxt;
    end
  end

  // in capture mode both io lines are inputs; drivers stay released
  logic oe_n_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= 1'b1;
    end
  end

  assign prdata         = prdata_r;
  assign pready         = pready_r;
  assign pslverr        = perr_r;
  assign count_running  = run_r;
  assign io_line_a_o    = 1'b0 & oe_n_r;
  assign io_line_b_o    = 1'b0 & oe_n_r;
  assign io_line_a_oe_n = oe_n_r;
  assign io_line_b_oe_n = oe_n_r;

endmodule : timer_channel_capture_control

// ### verification/tcc_checker_assertions.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_checker #(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              block_sync,
  input wire logic              io_line_a_o,
  input wire logic              io_line_a_oe_n,
  input wire logic              io_line_b_o,
  input wire logic              io_line_b_oe_n,
  input wire logic              count_running
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  // a command word taken at this edge
  logic cmd_wr;
  assign cmd_wr = psel & penable & pready & pwrite & (paddr == `TCC_CMD_OFF);
  ////////////////////////////////////////////////////////////////
  property p_ready_setup; psel && !penable |=> pready; endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_err_ready; pslverr |-> pready && psel && penable; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error outside access");
  property p_unmapped; pready && paddr == 8'h08 |-> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole not refused");
  property p_wo_read; pready && !pwrite && paddr == `TCC_CMD_OFF |-> prdata == 32'h0 && !pslverr; endproperty
  a_wo_read: assert property (p_wo_read) else $error("command word readable");
  property p_clk_on; cmd_wr && pwdata[0] && !pwdata[1] && pwdata[2] |=> count_running; endproperty
  a_clk_on: assert property (p_clk_on) else $error("clock not started");
  property p_clk_off; cmd_wr && pwdata[1] |=> !count_running [*2]; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock not stopped");
  property p_sync_keep; block_sync && count_running && !cmd_wr |=> count_running; endproperty
  a_sync_keep: assert property (p_sync_keep) else $error("sync stopped clock");
  property p_no_drive; io_line_a_oe_n && io_line_b_oe_n && !io_line_a_o && !io_line_b_o; endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven in capture");
  property p_stop_cause; $fell(count_running) && !$past(cmd_wr) |-> !$past(block_sync); endproperty
  a_stop_cause: assert property (p_stop_cause) else $error("stop beside sync");
  // main scenarios seen
  c_trig: cover property (cmd_wr && pwdata[2]);
  c_err: cover property (pslverr);
  c_load_stop: cover property ($fell(count_running) && !$past(cmd_wr));
endmodule : tcc_checker
bind timer_channel_capture_control tcc_checker #(.ADDR_W(ADDR_W)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .block_sync(block_sync), .io_line_a_o(io_line_a_o), .io_line_a_oe_n(io_line_a_oe_n), .io_line_b_o(io_line_b_o),
  .io_line_b_oe_n(io_line_b_oe_n), .count_running(count_running));

// ### verification/tcc_far_side.sv
`timescale 1ns/1ps
// trigger, capture and clock sources outside the channel
module tcc_far_side (
  input wire logic  pclk,
  output logic [4:0] lines  // 0 line a, 1 line b, 2..4 ext clocks
);
  initial lines = 5'h00;
  // levels change only after an edge and stand hold cycles, so the sync sees them
  task set(input int idx, input logic v, input int hold);
    @(posedge pclk);
    lines[idx] <= v;
    repeat (hold) @(posedge pclk);
  endtask : set
  // n rising edges, line left high: one fewer falling edge than rising
  task pulses(input int idx, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      set(idx, 1'b1, half);
      if (i < n - 1) set(idx, 1'b0, half);
    end
  endtask : pulses
endmodule : tcc_far_side

// ### verification/timer_channel_capture_control_bench.sv
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module timer_channel_capture_control_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_sync = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, cap_a;
  logic        pready, pslverr, er, count_running;
  logic [4:0]  lines;
  int          miscompares = 0, compares = 0, cyc = 0;
  always #5 pclk = ~pclk;
  tcc_far_side far_u (.pclk(pclk), .lines(lines));
  timer_channel_capture_control dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .block_sync(block_sync), .io_line_a_i(lines[0]), .io_line_a_o(), .io_line_a_oe_n(),
    .io_line_b_i(lines[1]), .io_line_b_o(), .io_line_b_oe_n(), .ext_clock_0(lines[2]),
    .ext_clock_1(lines[3]), .ext_clock_2(lines[4]), .count_running(count_running));
  ////////////////////////////////////////////////////////////////
  // one apb transfer; pready is read before the edge's updates land
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no wait-state count is assumed; only the bench timeout ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : xfer
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // counts depend on divider phase, so a window is allowed
  task rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    compares++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      miscompares++;
      $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask : rng
  function automatic int ratio(input int s);
    return s < 4 ? 2 << (2 * s) : 1024;
  endfunction : ratio
  // does edge kind k[4] on line k[3] fire with field k[1:0] and select k[2]
  function automatic logic trig_hit(input logic [4:0] k);
    return (k[2] != k[3]) && (k[4] ? k[0] : k[1]);
  endfunction : trig_hit
  task give_verdict;
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // a hang ends the run as a failure
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(86));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    // reset values, refusals, read-only and write-only places
    xfer(0, `TCC_MODE_OFF, 0); chk("mode_reset", 32'h0, rd);
    xfer(0, 8'h08, 0); chk("hole_err", 32'h1, {31'h0, er});
    xfer(0, `TCC_CMD_OFF, 0); chk("cmd_read", 32'h0, rd);
    xfer(1, `TCC_COUNT_OFF, 32'h1234); xfer(0, `TCC_COUNT_OFF, 0); chk("count_ro", 32'h0, rd);
    repeat (6) begin
      v = $urandom;
      xfer(1, `TCC_MODE_OFF, v); xfer(0, `TCC_MODE_OFF, 0); chk("mode_rw", v & `TCC_MODE_MASK, rd);
    end
    // command table: on, on+off, zero, off, on, zero
    for (int i = 0; i < 6; i++) begin
      xfer(1, `TCC_CMD_OFF, {29'h0, 3'({3'd1, 3'd3, 3'd0, 3'd2, 3'd1, 3'd0} >> (3 * (5 - i)))});
      repeat (2) @(posedge pclk);
      chk("running", (i == 0 || i >= 4), count_running);
    end
    // master clock ratios, eight counts each
    for (int s = 0; s < 5; s++) begin
      xfer(1, `TCC_MODE_OFF, s); xfer(1, `TCC_CMD_OFF, 32'h5);
      repeat (8 * ratio(s)) @(posedge pclk);
      xfer(0, `TCC_COUNT_OFF, 0); rng("master_src", 7, 11, rd);
    end
    // external clocks, rising or falling edge
    for (int x = 0; x < 6; x++) begin
      far_u.set(2 + x / 2, 1'b0, 4);
      xfer(1, `TCC_MODE_OFF, 5 + x / 2 + 8 * (x % 2)); xfer(1, `TCC_CMD_OFF, 32'h5);
      far_u.pulses(2 + x / 2, 6, 4);
      xfer(0, `TCC_COUNT_OFF, 0); chk("ext_count", 6 - x % 2, rd);
    end
    // gating: gate low freezes, gate high lets /2 through
    for (int g = 2; g < 8; g++) begin
      far_u.set(1 + g / 2, g[0], 4);
      xfer(1, `TCC_MODE_OFF, (g / 2) << 4); xfer(1, `TCC_CMD_OFF, 32'h5);
      repeat (40) @(posedge pclk);
      xfer(0, `TCC_COUNT_OFF, 0); rng("gated", g[0] ? 17 : 0, g[0] ? 25 : 0, rd);
    end
    // external trigger: every edge field, line select, line and edge kind
    for (int k = 0; k < 32; k++) begin
      far_u.set(k / 8 % 2, !k[4], 4);
      xfer(1, `TCC_MODE_OFF, (k % 4) << 8 | (k / 4 % 2) << 10); xfer(1, `TCC_CMD_OFF, 32'h5);
      repeat (80) @(posedge pclk);
      far_u.set(k / 8 % 2, k[4], 8);
      xfer(0, `TCC_COUNT_OFF, 0);
      rng("ext_trig", trig_hit(5'(k)) ? 0 : 40, trig_hit(5'(k)) ? 12 : 70, rd);
    end
    // compare c restart on and off
    xfer(1, `TCC_CMPC_OFF, 32'd20);
    for (int m = 0; m < 2; m++) begin
      xfer(1, `TCC_MODE_OFF, m << 14); xfer(1, `TCC_CMD_OFF, 32'h5);
      repeat (200) @(posedge pclk);
      xfer(0, `TCC_COUNT_OFF, 0); rng("match_c", m ? 0 : 95, m ? 21 : 110, rd);
    end
    // captures: a on rise, b on fall; b load plain, halting, disabling
    far_u.set(0, 1'b0, 4);
    for (int m = 0; m < 3; m++) begin
      xfer(1, `TCC_MODE_OFF, 32'h0009_0000 | (m == 1) << 6 | (m == 2) << 7);
      xfer(1, `TCC_CMD_OFF, 32'h5);
      repeat (40) @(posedge pclk);
      far_u.set(0, 1'b1, 60);
      far_u.set(0, 1'b0, 20);
      xfer(0, `TCC_CAPA_OFF, 0); cap_a = rd;
      xfer(0, `TCC_CAPB_OFF, 0); rng("cap_gap", 27, 33, rd - cap_a);
      chk("run_after_load", m == 0, count_running);
      @(posedge pclk) block_sync <= 1;
      @(posedge pclk) block_sync <= 0;
      repeat (3) @(posedge pclk);
      chk("sync_restart", m != 2, count_running);
    end
    // sync word: a running counter restarts from zero
    xfer(1, `TCC_CMD_OFF, 32'h1);
    repeat (20) @(posedge pclk);
    xfer(1, `TCC_SYNC_OFF, 32'h1); xfer(0, `TCC_COUNT_OFF, 0); rng("sync_word", 0, 2, rd);
    // waveform bit set: edges on line a load nothing
    xfer(1, `TCC_MODE_OFF, 32'h0009_8000);
    far_u.pulses(0, 2, 6);
    xfer(0, `TCC_CAPA_OFF, 0); chk("wave_no_load", cap_a, rd);
    give_verdict;
  end
endmodule : timer_channel_capture_control_bench
